// [logic/rsx_pkg.sv]
// Shared constants and types for the rotate, subtract and skip execution datapath.
package rsx_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] CMD_OFFSET     = 8'h00;
    localparam logic [7:0] OPERAND_OFFSET = 8'h04;
    localparam logic [7:0] ACC_OFFSET     = 8'h08;
    localparam logic [7:0] FLAG_OFFSET    = 8'h0c;
    localparam logic [7:0] MEM_OFFSET     = 8'h10;
    localparam logic [7:0] STATUS_OFFSET  = 8'h14;

    // Command register fields.
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_BIT_LSB = 4;

    // Status register fields.
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_SKIP_BIT = 1;
    localparam int STATUS_MEMW_BIT = 2;
    localparam int STATUS_CYC_LSB  = 4;

    // Values after reset.
    localparam logic [7:0] ACC_RESET     = 8'h00;
    localparam logic [7:0] OPERAND_RESET = 8'h00;
    localparam logic [3:0] FLAG_RESET    = 4'h0;

    // Cycle counts of an instruction without and with a taken skip.
    localparam logic [1:0] ONE_CYCLE  = 2'h1;
    localparam logic [1:0] TWO_CYCLES = 2'h2;

    // Constant operands.
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ONE_BYTE = 8'h01;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operation codes written into the command register.
    typedef enum logic [3:0] {
        rotate_right_carry_to_acc  = 4'h0,
        subtract_carry_to_acc      = 4'h1,
        subtract_carry_to_mem      = 4'h2,
        decrement_skip_zero        = 4'h3,
        decrement_to_acc_skip_zero = 4'h4,
        set_byte                   = 4'h5,
        set_bit                    = 4'h6,
        increment_skip_zero        = 4'h7,
        increment_to_acc_skip_zero = 4'h8,
        skip_bit_nonzero           = 4'h9,
        subtract_to_acc            = 4'ha,
        subtract_to_mem            = 4'hb,
        subtract_immediate         = 4'hc,
        swap_nibbles               = 4'hd
    } op_t;

    // Status flags, packed in register order (carry in bit 0).
    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } flags_t;

    // Output of the complement adder.
    typedef struct packed {
        logic [7:0] sum;
        flags_t     flags;
    } sub_result_t;

    // Execution sequencer states.
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_exec  = 3'b010,
        st_dummy = 3'b100
    } state_t;

endpackage

// [logic/complement_adder.sv]
// Complement adder: a plus the one's complement of b plus a carry in.
module complement_adder
    import rsx_pkg::*;
(
    // Operands
    input  wire logic [7:0]  a,
    input  wire logic [7:0]  b,
    input  wire logic        carry_in,
    // Result with flags
    output sub_result_t      result
);

    logic [4:0] low_sum;
    logic [4:0] high_sum;
    logic [7:0] b_inv;

    // Split at the nibble so the bit-3-to-bit-4 carry is visible.
    assign b_inv    = ~b;
    assign low_sum  = {1'b0, a[3:0]} + {1'b0, b_inv[3:0]} + {4'h0, carry_in};
    assign high_sum = {1'b0, a[7:4]} + {1'b0, b_inv[7:4]} + {4'h0, low_sum[4]};

    // Carry set means no borrow; overflow on a sign change between like signs.
    assign result.sum                   = {high_sum[3:0], low_sum[3:0]}; // see (RULE15)
    assign result.flags.carry_flag      = high_sum[4]; // see (RULE15)
    assign result.flags.half_carry_flag = low_sum[4]; // see (RULE15)
    assign result.flags.zero_flag       = ({high_sum[3:0], low_sum[3:0]} == 8'h00);
    assign result.flags.overflow_flag   = (a[7] == b_inv[7]) && (high_sum[3] != a[7]);

endmodule

// [logic/rsx_exec.sv]
// Rotate, subtract, set, skip and swap datapath behind an AXI4-Lite port.
//
// What this block does
// (RULE1) Rotate right through carry: operand into accumulator, bit 0 to carry.
// (RULE2) Subtract with carry to accumulator: acc plus ~operand plus carry, all flags.
// (RULE3) Subtract with carry to memory: same sum written back, all flags.
// (RULE4) Decrement memory, skip with a dummy cycle when the result is zero.
// (RULE5) Decrement into accumulator, memory unchanged, skip on zero, no flags.
// (RULE6) Set byte writes all ones to memory, flags untouched.
// (RULE7) Set bit forces only the selected memory bit to one.
// (RULE8) Increment memory, skip with a dummy cycle when it wraps to zero.
// (RULE9) Increment into accumulator, memory unchanged, skip on zero, no flags.
// (RULE10) Skip when the selected operand bit is one, else continue, nothing changes.
// (RULE11) Subtract operand from accumulator into accumulator, all flags.
// (RULE12) Subtract operand from accumulator into memory, all flags.
// (RULE13) Subtract immediate from accumulator into accumulator, all flags.
// (RULE14) Swap the two nibbles of the memory byte in place.
// (RULE15) Subtract carry means no borrow; half carry is the bit 3 carry.
module rsx_exec
    import rsx_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Data memory write-back and fetch control
    output logic [7:0]       mem_wr_data,
    output logic             mem_wr_en,
    output logic             discard_fetch
);

    ////////////
    // Architectural state.

    state_t      state;
    state_t      next_state;
    logic [7:0]  accumulator_reg;
    flags_t      flags;
    logic [7:0]  operand;
    op_t         op;
    logic [2:0]  bit_sel;
    logic [7:0]  mem_result;
    logic        last_skip;
    logic        last_memw;
    logic [1:0]  last_cycles;

    ////////////
    // Write channel handshake.

    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        aw_take;
    logic        w_take;
    logic        aw_have;
    logic        w_have;
    logic        wr_do;
    logic        next_aw_full;
    logic        next_w_full;
    logic        next_bvalid;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        wr_lane0;
    logic        wr_mapped;

    // Address and data are taken in either order; the write happens once both are held.
    assign aw_take      = s_axi_awvalid && s_axi_awready;
    assign w_take       = s_axi_wvalid && s_axi_wready;
    assign aw_have      = aw_full || aw_take;
    assign w_have       = w_full || w_take;
    assign wr_do        = aw_have && w_have;
    assign next_aw_full = aw_have && !wr_do;
    assign next_w_full  = w_have && !wr_do;
    assign next_bvalid  = wr_do || (s_axi_bvalid && !s_axi_bready);
    assign wr_addr      = aw_full ? aw_addr_q : s_axi_awaddr;
    assign wr_data      = w_full ? w_data_q : s_axi_wdata;
    assign wr_lane0     = w_full ? w_strb_q[0] : s_axi_wstrb[0];

    // Decode of the write target; only byte lane 0 carries register data.
    logic wr_cmd, wr_operand, wr_acc, wr_flag;

    assign wr_cmd     = wr_do && wr_lane0 && (wr_addr == CMD_OFFSET);
    assign wr_operand = wr_do && wr_lane0 && (wr_addr == OPERAND_OFFSET);
    assign wr_acc     = wr_do && wr_lane0 && (wr_addr == ACC_OFFSET);
    assign wr_flag    = wr_do && wr_lane0 && (wr_addr == FLAG_OFFSET);
    assign wr_mapped  = (wr_addr[1:0] == 2'b00) && (wr_addr <= STATUS_OFFSET);

    // Readies drop while a response is pending, so one write at a time is under way.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready  <= !next_w_full && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
        end
    end

    // Held address, data and response code.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_addr_q   <= 8'h00;
            w_data_q    <= 32'h0000_0000;
            w_strb_q    <= 4'h0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////
    // Read channel.

    logic        ar_take;
    logic        next_rvalid;
    logic [31:0] rd_value;
    logic        rd_mapped;
    logic [31:0] status_word;

    assign ar_take     = s_axi_arvalid && s_axi_arready;
    assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

    // Status shows the sequencer and the outcome of the last operation.
    assign status_word = {26'h0, last_cycles, 1'b0, last_memw, last_skip, (state != st_idle)};

    // Read mux; unused upper bits read as zero.
    assign rd_mapped = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= STATUS_OFFSET);
    assign rd_value  = (s_axi_araddr == CMD_OFFSET)     ? {24'h0, 1'b0, bit_sel, op} :
                       (s_axi_araddr == OPERAND_OFFSET) ? {24'h0, operand} :
                       (s_axi_araddr == ACC_OFFSET)     ? {24'h0, accumulator_reg} :
                       (s_axi_araddr == FLAG_OFFSET)    ? {28'h0, flags} :
                       (s_axi_araddr == MEM_OFFSET)     ? {24'h0, mem_result} :
                       (s_axi_araddr == STATUS_OFFSET)  ? status_word : 32'h0000_0000;

    // One read at a time; data answer one cycle after the address is taken.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////
    // Datapath.

    sub_result_t sub_out;
    logic        sub_carry_in;
    logic        uses_carry;
    logic [7:0]  dec_value;
    logic [7:0]  inc_value;
    logic [7:0]  bit_mask;

    // Subtract-with-carry feeds the carry flag in; plain subtract feeds a one.
    assign uses_carry   = (op == subtract_carry_to_acc) || (op == subtract_carry_to_mem);
    assign sub_carry_in = uses_carry ? flags.carry_flag : 1'b1; // see (RULE2) (RULE11)
    assign dec_value    = operand - ONE_BYTE;
    assign inc_value    = operand + ONE_BYTE;
    assign bit_mask     = ONE_BYTE << bit_sel;

    complement_adder u_adder (
        .a        (accumulator_reg),
        .b        (operand),
        .carry_in (sub_carry_in),
        .result   (sub_out)
    );

    logic [7:0] next_acc;
    flags_t     next_flags;
    logic [7:0] next_mem;
    logic       next_memw;
    logic       next_skip;

    // Outcome of the current operation; anything not named leaves its state alone.
    always_comb begin
        next_acc   = accumulator_reg;
        next_flags = flags;
        next_mem   = operand;
        next_memw  = 1'b0;
        next_skip  = 1'b0;
        unique case (op)
            rotate_right_carry_to_acc: begin
                next_acc              = {flags.carry_flag, operand[7:1]}; // see (RULE1)
                next_flags.carry_flag = operand[0]; // see (RULE1)
            end
            subtract_carry_to_acc, subtract_to_acc, subtract_immediate: begin
                next_acc   = sub_out.sum; // see (RULE2) (RULE11) (RULE13)
                next_flags = sub_out.flags; // see (RULE2) (RULE11) (RULE13)
            end
            subtract_carry_to_mem, subtract_to_mem: begin
                next_mem   = sub_out.sum; // see (RULE3) (RULE12)
                next_memw  = 1'b1;
                next_flags = sub_out.flags; // see (RULE3) (RULE12)
            end
            decrement_skip_zero: begin
                next_mem  = dec_value; // see (RULE4)
                next_memw = 1'b1;
                next_skip = (dec_value == 8'h00); // see (RULE4)
            end
            decrement_to_acc_skip_zero: begin
                next_acc  = dec_value; // see (RULE5)
                next_skip = (dec_value == 8'h00); // see (RULE5)
            end
            set_byte: begin
                next_mem  = ALL_ONES; // see (RULE6)
                next_memw = 1'b1;
            end
            set_bit: begin
                next_mem  = operand | bit_mask; // see (RULE7)
                next_memw = 1'b1;
            end
            increment_skip_zero: begin
                next_mem  = inc_value; // see (RULE8)
                next_memw = 1'b1;
                next_skip = (inc_value == 8'h00); // see (RULE8)
            end
            increment_to_acc_skip_zero: begin
                next_acc  = inc_value; // see (RULE9)
                next_skip = (inc_value == 8'h00); // see (RULE9)
            end
            skip_bit_nonzero: begin
                next_skip = operand[bit_sel]; // see (RULE10)
            end
            swap_nibbles: begin
                next_mem  = {operand[3:0], operand[7:4]}; // see (RULE14)
                next_memw = 1'b1;
            end
            default: ;
        endcase
    end

    ////////////
    // Sequencer: a command runs one execute cycle, plus a dummy cycle on a skip.

    logic commit;
    assign commit = (state == st_exec);

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle:  next_state = wr_cmd ? st_exec : st_idle;
            st_exec:  next_state = next_skip ? st_dummy : st_idle; // see (RULE4) (RULE10)
            st_dummy: next_state = st_idle;
            default:  next_state = st_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // A command written while busy is dropped, so op and bit_sel hold through execute.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op      <= rotate_right_carry_to_acc;
            bit_sel <= 3'h0;
        end else if (wr_cmd && (state == st_idle)) begin
            op      <= op_t'(wr_data[CMD_OP_LSB +: 4]);
            bit_sel <= wr_data[CMD_BIT_LSB +: 3];
        end
    end

    // Operand is the memory byte or the immediate, loaded only while idle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            operand <= OPERAND_RESET;
        end else if (wr_operand && (state == st_idle)) begin
            operand <= wr_data[7:0];
        end
    end

    // Accumulator and flags: the datapath wins over a software write in the commit cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            accumulator_reg <= ACC_RESET;
            flags           <= flags_t'(FLAG_RESET);
        end else if (commit) begin
            accumulator_reg <= next_acc;
            flags           <= next_flags;
        end else begin
            if (wr_acc) begin
                accumulator_reg <= wr_data[7:0];
            end
            if (wr_flag) begin
                flags <= flags_t'(wr_data[3:0]);
            end
        end
    end

    // Outcome of the last operation, kept for software.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_result  <= OPERAND_RESET;
            last_skip   <= 1'b0;
            last_memw   <= 1'b0;
            last_cycles <= 2'h0;
        end else if (commit) begin
            mem_result  <= next_memw ? next_mem : operand;
            last_skip   <= next_skip;
            last_memw   <= next_memw;
            last_cycles <= next_skip ? TWO_CYCLES : ONE_CYCLE; // see (RULE4) (RULE8)
        end
    end

    // Memory write strobe and prefetch discard come straight from flops.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_wr_data   <= 8'h00;
            mem_wr_en     <= 1'b0;
            discard_fetch <= 1'b0;
        end else begin
            mem_wr_en     <= commit && next_memw;
            discard_fetch <= commit && next_skip; // see (RULE4) (RULE10)
            if (commit && next_memw) begin
                mem_wr_data <= next_mem;
            end
        end
    end

endmodule

// [testbench/rsx_exec_sva.sv]
// Concurrent checks on the ports of the rotate, subtract and skip datapath.
module rsx_exec_sva
    import rsx_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Bus signals watched
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    // Memory write-back and fetch control
    input wire logic [7:0]  mem_wr_data,
    input wire logic        mem_wr_en,
    input wire logic        discard_fetch
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // A command write taken at this edge; the bench never sends one while busy.
    wire logic       go;
    wire logic [3:0] go_op;
    assign go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                && s_axi_awaddr == CMD_OFFSET;
    assign go_op = s_axi_wdata[3:0];

    ////////////
    // Bus and pulse shape.
    AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !mem_wr_en && !discard_fetch
        && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready) else $error("outputs busy at reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    AST_MEMW_PULSE: assert property (mem_wr_en |=> !mem_wr_en) else $error("write-back too long");

    ////////////
    // Per-operation effects two cycles after the command is taken.
    AST_ROTATE: assert property (go && go_op == rotate_right_carry_to_acc |-> ##2 !mem_wr_en
        && !discard_fetch) else $error("rotate touched memory");
    AST_DEC_SKIP: assert property (go && go_op == decrement_skip_zero |-> ##2 mem_wr_en
        && discard_fetch == (mem_wr_data == 8'h00)) else $error("decrement skip wrong");
    AST_DEC_ACC: assert property (go && go_op == decrement_to_acc_skip_zero
        |-> ##2 !mem_wr_en) else $error("decrement to acc wrote memory");
    AST_SET_BYTE: assert property (go && go_op == set_byte |-> ##2 mem_wr_en
        && mem_wr_data == ALL_ONES && !discard_fetch) else $error("set byte wrong");
    AST_SET_BIT: assert property (go && go_op == set_bit |-> ##2 mem_wr_en
        && mem_wr_data[$past(s_axi_wdata[6:4], 2)]) else $error("set bit not set");
    AST_INC_SKIP: assert property (go && go_op == increment_skip_zero |-> ##2 mem_wr_en
        && discard_fetch == (mem_wr_data == 8'h00)) else $error("increment skip wrong");
    AST_INC_ACC: assert property (go && go_op == increment_to_acc_skip_zero
        |-> ##2 !mem_wr_en) else $error("increment to acc wrote memory");
    AST_SUB_MEM: assert property (go && go_op == subtract_to_mem |-> ##2 mem_wr_en
        && !discard_fetch) else $error("subtract to memory no write");
    AST_SWAP: assert property (go && go_op == swap_nibbles |-> ##2 mem_wr_en
        && !discard_fetch) else $error("swap no write");

    // Main scenarios reached.
    cover property (discard_fetch);
    cover property (mem_wr_en && mem_wr_data == ALL_ONES);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind rsx_exec rsx_exec_sva u_sva (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .mem_wr_data, .mem_wr_en, .discard_fetch
);

// [testbench/tb_rotate_subtract_skip_exec.sv]
// Self-checking bench for the rotate, subtract and skip datapath.
module tb_rotate_subtract_skip_exec;
    import rsx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, sys_rst;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_wr_data, cap;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        mem_wr_en, discard_fetch;
    int          err_count, n_checks, n_memw, n_skip;
    logic [31:0] seed = 32'hab4e6348;
    int          corner[$] = '{1, 255, 0, 128};

    rsx_exec dut (
        .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_wr_data, .mem_wr_en, .discard_fetch
    );

    ////////////
    // Clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Counts pulses mid-cycle, clear of the edge that launches them.
    always @(negedge clk) begin
        if (mem_wr_en === 1'b1) begin
            n_memw++;
            cap = mem_wr_data;
        end
        if (discard_fetch === 1'b1) n_skip++;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////
    // Bus master: handshakes are sampled mid-cycle, so the edge never races the design.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int t;
        logic aw, w, b;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(negedge clk);
            {aw, w, b} = {s_axi_awready === 1'b1, s_axi_wready === 1'b1, s_axi_bvalid === 1'b1};
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        if (t == 50) chk(1'b0, 1'b1, "write hang");
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int t;
        logic ar, rv;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(negedge clk);
            {ar, rv} = {s_axi_arready === 1'b1, s_axi_rvalid === 1'b1};
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) break;
        end
        if (t == 50) chk(1'b0, 1'b1, "read hang");
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    ////////////
    // Loads operands, runs one command and compares with the integer model.
    task automatic run_op(input int op, input int p);
        int opd, acc, fl, bi, nb, cin, s, h, ov, sk, mw, eacc, efl, emem, t;
        logic [31:0] d;
        logic [1:0]  r;
        opd = (p < corner.size()) ? corner[p] : int'(xs() & 32'hff);
        acc = int'(xs() & 32'hff);
        fl = int'(xs() & 32'hf);
        bi = int'(xs() & 32'h7);
        eacc = acc;
        efl = fl;
        emem = opd;
        sk = 0;
        mw = 0;
        // Subtraction adds the complement, so carry means no borrow.
        if (op inside {1, 2, 10, 11, 12}) begin
            nb = ~opd & 255;
            cin = (op < 3) ? (fl & 1) : 1;
            s = acc + nb + cin;
            h = (acc & 15) + (nb & 15) + cin;
            ov = (((acc ^ nb) & 128) == 0 && ((acc ^ s) & 128) != 0) ? 1 : 0;
            efl = (ov << 3) | (((s & 255) == 0) << 2) | ((h > 15) << 1) | (s > 255);
            if (op == 2 || op == 11) emem = s & 255;
            else eacc = s & 255;
            mw = (op == 2 || op == 11);
        end
        case (op)
            0: begin
                eacc = ((fl & 1) << 7) | (opd >> 1);
                efl = (fl & 14) | (opd & 1);
            end
            3: emem = (opd - 1) & 255;
            4: eacc = (opd - 1) & 255;
            5: emem = 255;
            6: emem = opd | (1 << bi);
            7: emem = (opd + 1) & 255;
            8: eacc = (opd + 1) & 255;
            9: sk = (opd >> bi) & 1;
            13: emem = ((opd & 15) << 4) | (opd >> 4);
            default: ;
        endcase
        if (op inside {3, 5, 6, 7, 13}) mw = 1;
        if (op == 3 || op == 7) sk = (emem == 0);
        if (op == 4 || op == 8) sk = (eacc == 0);
        axi_wr(OPERAND_OFFSET, opd, r);
        axi_wr(ACC_OFFSET, acc, r);
        axi_wr(FLAG_OFFSET, fl, r);
        n_memw = 0;
        n_skip = 0;
        axi_wr(CMD_OFFSET, (bi << CMD_BIT_LSB) | op, r);
        for (t = 0; t < 20; t++) begin
            axi_rd(STATUS_OFFSET, d, r);
            if (d[STATUS_BUSY_BIT] === 1'b0) break;
        end
        chk(n_memw, mw, "write-back pulses");
        chk(n_skip, sk, "discard pulses");
        if (mw == 1) chk(cap, emem, "write-back data");
        chk(d, ((sk + 1) << STATUS_CYC_LSB) | (mw << 2) | (sk << 1), "status");
        axi_rd(ACC_OFFSET, d, r);
        chk(d, eacc, "accumulator");
        axi_rd(FLAG_OFFSET, d, r);
        chk(d, efl, "flags");
        axi_rd(MEM_OFFSET, d, r);
        chk(d, emem, "memory result");
    endtask

    ////////////
    // Main sequence: reset, register defaults, unmapped access, every operation.
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        axi_rd(ACC_OFFSET, d, r);
        chk(d, ACC_RESET, "acc after reset");
        axi_rd(FLAG_OFFSET, d, r);
        chk(d, FLAG_RESET, "flags after reset");
        axi_rd(8'h20, d, r);
        chk(r, RESP_SLVERR, "unmapped read");
        axi_wr(8'h20, 32'h0000_00ff, r);
        chk(r, RESP_SLVERR, "unmapped write");
        for (int op = 0; op < 14; op++) begin
            for (int p = 0; p < 6; p++) run_op(op, p);
        end
        stop_test();
    end

    // Watchdog far past the few thousand cycles a run takes.
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
endmodule
